// *** spi_rate_status_data_regs.sv ***
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "spi_rate_status_params.svh"

module spi_rate_status_data_regs
  import spi_rate_status_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             sckOut,
  output logic             mosiOut,
  input  wire logic        misoIn,
  input  wire logic        ssIn_n,
  output logic             ssOut_n,
  output logic             ssOutEn
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  apb_req_t    req;
  ctrl1_t      ctrl1_q,    ctrl1_d;
  logic [7:0]  ctrl2_q,    ctrl2_d;
  logic [7:0]  rate_q,     rate_d;
  logic [7:0]  txBuf_q,    txBuf_d;
  logic        txFull_q,   txFull_d;
  logic [7:0]  rxBuf_q,    rxBuf_d;
  logic        rxFull_q,   rxFull_d;
  logic        mode_fault_flag_q,     mode_fault_flag_d;
  logic        txArm_q,    txArm_d;
  logic        rxArm_q,    rxArm_d;
  logic        mfArm_q,    mfArm_d;
  logic [7:0]  shift_q,    shift_d;
  logic        rxBit_q,    rxBit_d;
  logic [3:0]  edgeCnt_q,  edgeCnt_d;
  logic [2:0]  preCnt_q,   preCnt_d;
  logic [7:0]  divCnt_q,   divCnt_d;
  logic        sck_q,      sck_d;
  xfer_state_t state_q,    state_d;
  logic [31:0] prdata_q,   prdata_d;
  logic        ssMeta_q;
  logic        ssSync_q;
  logic        ssPrev_q;
  logic        misoMeta_q;
  logic        misoSync_q;

  logic        setupPh;
  logic        accessPh;
  logic        mapped;
  logic        wrAcc;
  logic        rdAcc;
  logic        dataWr;
  logic        dataRd;
  logic        flagsRd;
  logic        rxClr;
  logic        xferDone;
  logic        preTick;
  logic        halfTick;
  logic [7:0]  halfLimit;
  logic        faultEdge;
  logic [7:0]  flagsView;
  logic        mode_fault_enable;

  assign req = '{addr: paddr, sel: psel, enable: penable, write: pwrite,
                 wdata: pwdata};

  ////////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states
  always_comb begin
    mapped = (req.addr == `ADDR_CTRL1) || (req.addr == `ADDR_CTRL2) ||
             (req.addr == `ADDR_RATE)  || (req.addr == `ADDR_FLAGS) ||
             (req.addr == `ADDR_DATA);
  end

  assign setupPh  = req.sel && !req.enable;
  assign accessPh = req.sel && req.enable;
  assign wrAcc    = accessPh && req.write;
  assign rdAcc    = accessPh && !req.write;
  assign dataWr   = wrAcc && (req.addr == `ADDR_DATA);
  assign dataRd   = rdAcc && (req.addr == `ADDR_DATA);
  assign flagsRd  = rdAcc && (req.addr == `ADDR_FLAGS);
  assign pready   = 1'b1;
  assign pslverr  = accessPh && !mapped;
  assign prdata   = prdata_q;
  assign mode_fault_enable   = ctrl2_q[`CTRL2_MODE_FAULT_FLAG_EN];

  always_comb begin
    flagsView = 8'h00;
    flagsView[`FLAG_RX_FULL]    = rxFull_q;
    flagsView[`FLAG_TX_EMPTY]   = !txFull_q;
    flagsView[`FLAG_MODE_FAULT] = mode_fault_flag_q;
  end

  // read data captured in the setup phase, presented in the access phase
  always_comb begin
    prdata_d = prdata_q;
    if (setupPh) begin
      unique case (req.addr)
        `ADDR_CTRL1: prdata_d = {24'h000000, ctrl1_q};
        `ADDR_CTRL2: prdata_d = {24'h000000, ctrl2_q};
        `ADDR_RATE:  prdata_d = {24'h000000, rate_q};
        `ADDR_FLAGS: prdata_d = {24'h000000, flagsView};
        `ADDR_DATA:  prdata_d = {24'h000000, rxBuf_q};
        default:     prdata_d = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit rate generator from the bus clock
  assign halfLimit = 8'((9'h001 << rate_q[`RATE_DIV_MSB:`RATE_DIV_LSB]) - 9'h001);
  assign preTick   = (preCnt_q == rate_q[`RATE_PRE_MSB:`RATE_PRE_LSB]);
  assign halfTick  = (state_q == ST_SHIFT) && preTick &&
                     (divCnt_q == halfLimit);
  assign xferDone  = halfTick && (edgeCnt_q == `EDGES_PER_BYTE);
  assign rxClr     = dataRd && rxArm_q;
  assign faultEdge = ctrl1_q.masterSel && mode_fault_enable && !ctrl1_q.selOutEn &&
                     ssPrev_q && !ssSync_q;

  always_comb begin
    preCnt_d = 3'h0;
    divCnt_d = 8'h00;
    if (state_q == ST_SHIFT) begin
      preCnt_d = preTick ? 3'h0 : 3'(preCnt_q + 3'h1);
      divCnt_d = divCnt_q;
      if (preTick) begin
        divCnt_d = (divCnt_q == halfLimit) ? 8'h00 : 8'(divCnt_q + 8'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, flags and shifter
  always_comb begin
    ctrl1_d   = ctrl1_q;
    ctrl2_d   = ctrl2_q;
    rate_d    = rate_q;
    txBuf_d   = txBuf_q;
    txFull_d  = txFull_q;
    rxBuf_d   = rxBuf_q;
    rxFull_d  = rxFull_q;
    mode_fault_flag_d    = mode_fault_flag_q;
    txArm_d   = txArm_q;
    rxArm_d   = rxArm_q;
    mfArm_d   = mfArm_q;
    shift_d   = shift_q;
    rxBit_d   = rxBit_q;
    edgeCnt_d = edgeCnt_q;
    sck_d     = sck_q;
    state_d   = state_q;

    // flag-read arms the matching clear sequence
    if (flagsRd) begin
      txArm_d = prdata_q[`FLAG_TX_EMPTY];
      rxArm_d = prdata_q[`FLAG_RX_FULL];
      mfArm_d = prdata_q[`FLAG_MODE_FAULT];
    end

    if (wrAcc) begin
      unique case (req.addr)
        `ADDR_CTRL1: ctrl1_d = ctrl1_t'(req.wdata[7:0]);
        `ADDR_CTRL2: ctrl2_d = req.wdata[7:0] & `CTRL2_MASK;
        `ADDR_RATE:  rate_d  = req.wdata[7:0] & `RATE_MASK;
        default:     ;
      endcase
    end

    if (wrAcc && (req.addr == `ADDR_CTRL1) && mfArm_q) begin
      mode_fault_flag_d  = 1'b0;
      mfArm_d = 1'b0;
    end
    if (faultEdge) begin
      mode_fault_flag_d = 1'b1;
    end

    if (dataWr && txArm_q) begin
      txBuf_d  = req.wdata[7:0];
      txFull_d = 1'b1;
      txArm_d  = 1'b0;
    end

    if (rxClr) begin
      rxFull_d = 1'b0;
      rxArm_d  = 1'b0;
    end

    unique case (state_q)
      ST_IDLE: begin
        sck_d     = 1'b0;
        edgeCnt_d = 4'h0;
        if (ctrl1_q.periphEn && ctrl1_q.masterSel && txFull_q) begin
          shift_d  = txBuf_q;
          txFull_d = 1'b0;
          state_d  = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (halfTick) begin
          sck_d     = !sck_q;
          edgeCnt_d = 4'(edgeCnt_q + 4'h1);
          if (!sck_q) begin
            rxBit_d = misoSync_q;
          end else begin
            shift_d = {shift_q[6:0], rxBit_q};
          end
        end
        if (xferDone) begin
          if (!rxFull_q || rxClr) begin
            rxBuf_d  = {shift_q[6:0], rxBit_q};
            rxFull_d = 1'b1;
          end
          if (txFull_q) begin
            shift_d  = txBuf_q;
            txFull_d = 1'b0;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
    endcase

    if (!ctrl1_q.periphEn) begin
      txFull_d  = 1'b0;
      rxFull_d  = 1'b0;
      txBuf_d   = `DATA_RESET;
      rxBuf_d   = `DATA_RESET;
      shift_d   = 8'h00;
      state_d   = ST_IDLE;
      sck_d     = 1'b0;
      edgeCnt_d = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl1_q    <= ctrl1_t'(`CTRL1_RESET);
      ctrl2_q    <= `CTRL2_RESET;
      rate_q     <= `RATE_RESET;
      txBuf_q    <= `DATA_RESET;
      txFull_q   <= 1'b0;
      rxBuf_q    <= `DATA_RESET;
      rxFull_q   <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      txArm_q    <= 1'b0;
      rxArm_q    <= 1'b0;
      mfArm_q    <= 1'b0;
      shift_q    <= 8'h00;
      rxBit_q    <= 1'b0;
      edgeCnt_q  <= 4'h0;
      preCnt_q   <= 3'h0;
      divCnt_q   <= 8'h00;
      sck_q      <= 1'b0;
      state_q    <= ST_IDLE;
      prdata_q   <= 32'h00000000;
      ssMeta_q   <= 1'b1;
      ssSync_q   <= 1'b1;
      ssPrev_q   <= 1'b1;
      misoMeta_q <= 1'b0;
      misoSync_q <= 1'b0;
    end else begin
      ctrl1_q    <= ctrl1_d;
      ctrl2_q    <= ctrl2_d;
      rate_q     <= rate_d;
      txBuf_q    <= txBuf_d;
      txFull_q   <= txFull_d;
      rxBuf_q    <= rxBuf_d;
      rxFull_q   <= rxFull_d;
      mode_fault_flag_q     <= mode_fault_flag_d;
      txArm_q    <= txArm_d;
      rxArm_q    <= rxArm_d;
      mfArm_q    <= mfArm_d;
      shift_q    <= shift_d;
      rxBit_q    <= rxBit_d;
      edgeCnt_q  <= edgeCnt_d;
      preCnt_q   <= preCnt_d;
      divCnt_q   <= divCnt_d;
      sck_q      <= sck_d;
      state_q    <= state_d;
      prdata_q   <= prdata_d;
      ssMeta_q   <= ssIn_n;
      ssSync_q   <= ssMeta_q;
      ssPrev_q   <= ssSync_q;
      misoMeta_q <= misoIn;
      misoSync_q <= misoMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and interrupt
  assign sckOut  = sck_q ^ ctrl1_q.clkPol;
  assign mosiOut = shift_q[7];
  assign ssOutEn = ctrl1_q.masterSel && mode_fault_enable && ctrl1_q.selOutEn;
  assign ssOut_n = (state_q != ST_SHIFT);
  assign irq     = (ctrl1_q.txIrqEn && !txFull_q) ||
                   (ctrl1_q.genIrqEn && (rxFull_q || mode_fault_flag_q));

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [11:0] gapCnt_q;
  logic [11:0] halfPeriod;

  assign halfPeriod = 12'(({9'h000, rate_q[`RATE_PRE_MSB:`RATE_PRE_LSB]} + 12'h001)
                      << rate_q[`RATE_DIV_MSB:`RATE_DIV_LSB]);

  always_ff @(posedge sys_clk) begin
    if (!reset_n || state_q != ST_SHIFT || halfTick) begin
      gapCnt_q <= 12'h000;
    end else begin
      gapCnt_q <= 12'(gapCnt_q + 12'h001);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_half_period_len: assert property (
    (halfTick && $stable(rate_q)) |-> (12'(gapCnt_q + 12'h001) == halfPeriod))
    else $error("serial clock half period wrong");

  a_flags_unused_zero: assert property (
    (setupPh && req.addr == `ADDR_FLAGS) |=> (prdata_q[6] == 1'b0 && prdata_q[3:0] == 4'h0))
    else $error("reserved flag bits not zero");

  a_data_wr_ignored: assert property (
    (dataWr && !txArm_q) |=> $stable(txBuf_q))
    else $error("unarmed data write changed buffer");

  a_idle_load_two: assert property (
    (dataWr && txArm_q && state_q == ST_IDLE && !txFull_q &&
     ctrl1_q.periphEn && ctrl1_q.masterSel && !(wrAcc && req.addr == `ADDR_CTRL1))
    |-> ##`IDLE_LOAD_CYC (!txFull_q && state_q == ST_SHIFT))
    else $error("idle byte not moved to shifter");

  a_rx_full_set: assert property (
    (xferDone && ctrl1_q.periphEn) |=> rxFull_q)
    else $error("receive full not set at end");

  a_overrun_keep: assert property (
    (xferDone && rxFull_q && !rxClr) |=> $stable(rxBuf_q))
    else $error("overrun replaced unread byte");

  a_rx_clear_seq: assert property (
    (rxFull_q && !rxArm_q && !xferDone && ctrl1_q.periphEn) |=> rxFull_q)
    else $error("receive full cleared without sequence");

  a_mode_fault_flag_cause: assert property (
    $rose(mode_fault_flag_q) |-> ($past(ctrl1_q.masterSel) && $past(mode_fault_enable) && !$past(ctrl1_q.selOutEn)))
    else $error("mode fault set while not enabled");

  a_mode_fault_flag_clear_seq: assert property (
    $fell(mode_fault_flag_q) |-> ($past(mfArm_q) && $past(wrAcc) && ($past(req.addr) == `ADDR_CTRL1)))
    else $error("mode fault cleared without sequence");

  a_tx_arm_write: assert property (
    $rose(txFull_q) |-> ($past(dataWr) && $past(txArm_q)))
    else $error("transmit buffer filled without armed write");

  a_disable_clear: assert property (
    !ctrl1_q.periphEn |=> (!rxFull_q && !txFull_q && state_q == ST_IDLE))
    else $error("disable left state behind");

  c_byte_done:  cover property (xferDone);
  c_overrun:    cover property (xferDone && rxFull_q && !rxClr);
  c_back2back:  cover property (xferDone && txFull_q);
  c_mode_fault: cover property ($rose(mode_fault_flag_q));

endmodule // spi_rate_status_data_regs

`default_nettype wire

// *** spi_rate_status_params.svh ***
`ifndef SPI_RATE_STATUS_PARAMS_SVH
`define SPI_RATE_STATUS_PARAMS_SVH

`define ADDR_CTRL1      8'h00
`define ADDR_CTRL2      8'h04
`define ADDR_RATE       8'h08
`define ADDR_FLAGS      8'h0C
`define ADDR_DATA       8'h10

`define RATE_PRE_MSB    6
`define RATE_PRE_LSB    4
`define RATE_DIV_MSB    2
`define RATE_DIV_LSB    0
`define FLAG_RX_FULL    7
`define FLAG_TX_EMPTY   5
`define FLAG_MODE_FAULT 4
`define CTRL2_MODE_FAULT_FLAG_EN   4

`define CTRL1_RESET     8'h04
`define CTRL2_RESET     8'h00
`define RATE_RESET      8'h00
`define DATA_RESET      8'h00
`define RATE_MASK       8'h77
`define CTRL2_MASK      8'h1B

`define IDLE_LOAD_CYC   2
`define EDGES_PER_BYTE  4'hF

`endif

// *** spi_rate_status_pkg.sv ***
package spi_rate_status_pkg;

  typedef struct packed {
    logic genIrqEn;
    logic periphEn;
    logic txIrqEn;
    logic masterSel;
    logic clkPol;
    logic clkPha;
    logic selOutEn;
    logic lsbFirst;
  } ctrl1_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        sel;
    logic        enable;
    logic        write;
    logic [31:0] wdata;
  } apb_req_t;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } xfer_state_t;

endpackage

// *** spi_slave_model.sv ***
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////
module spi_slave_model (
  input  wire logic       sckIn,
  input  wire logic       mosiIn,
  input  wire logic       selIn_n,
  input  wire logic [7:0] txByte,
  output logic            misoOut,
  output logic      [7:0] rxByte,
  output int              nRx
);
  logic [7:0] shTx;
  logic [7:0] shRx;
  int         nBit;
  initial begin
    misoOut = 1'b0;
    rxByte = 8'h00;
    nRx = 0;
    nBit = 0;
  end
  always @(negedge selIn_n) begin
    shTx = txByte;
    nBit = 0;
    misoOut = txByte[7];
  end
  // released line shows no stale bit
  always @(posedge selIn_n) misoOut = ~misoOut;
  always @(posedge sckIn) if (!selIn_n) begin
    shRx = {shRx[6:0], mosiIn};
    nBit = nBit + 1;
    if (nBit == 8) begin
      rxByte = shRx;
      nRx = nRx + 1;
    end
  end
  // reload after the eighth bit for back-to-back bytes
  always @(negedge sckIn) if (!selIn_n) begin
    if (nBit == 8) begin
      shTx = txByte;
      nBit = 0;
    end else begin
      shTx = shTx << 1;
    end
    misoOut = shTx[7];
  end
endmodule // spi_slave_model
`default_nettype wire

// *** tb_spi_rate_status_data_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "spi_rate_status_params.svh"
//////////////////////////////
module tb_spi_rate_status_data_regs
  import spi_rate_status_pkg::*;
;
  logic        sys_clk, reset_n, psel, penable, pwrite, ssIn_n;
  logic [7:0]  paddr, txByte, rxByte, sTx, r;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, sckOut, mosiOut, misoIn, ssOut_n, ssOutEn;
  logic [31:0] rnd = 32'hFBE146D8;
  logic [65:0] note;
  logic [65:0] rdQ[$];
  logic [7:0]  byteQ[$];
  int          nRx, n_errors, tests_run, seen, want, c;
  int          preT[4] = '{1, 2, 7, 0};
  int          divT[4] = '{1, 1, 2, 3};

  spi_rate_status_data_regs dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sckOut(sckOut), .mosiOut(mosiOut),
    .misoIn(misoIn), .ssIn_n(ssIn_n), .ssOut_n(ssOut_n), .ssOutEn(ssOutEn));
  spi_slave_model slave_u (.sckIn(sckOut), .mosiIn(mosiOut), .selIn_n(ssOut_n),
    .txByte(txByte), .misoOut(misoIn), .rxByte(rxByte), .nRx(nRx));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  //////////////////////////////
  function logic [7:0] rand8();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd[7:0];
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic timeout();
    n_errors++;
    report_and_stop();
  endtask
  // every transfer leaves a note {mask, expected} for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [32:0] m, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    rdQ.push_back({m, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h100000000, 33'h000000000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h1FFFFFF, m}, {25'h0000000, e});
  endtask
  task automatic send(input logic [7:0] d);
    rd(`ADDR_FLAGS, 8'h20, 8'h20);
    byteQ.push_back(d);
    want++;
    wr(`ADDR_DATA, d);
  endtask
  task automatic waitRx(input int t, input logic idle);
    int n;
    n = 0;
    while ((nRx < t || (idle && ssOut_n !== 1'b1)) && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20000) timeout();
  endtask
  task automatic halfPeriod(output int h);
    logic s;
    int n;
    n = 0;
    h = 0;
    s = sckOut;
    while (sckOut === s && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    s = sckOut;
    while (sckOut === s && h < 600) begin
      @(posedge sys_clk);
      h++;
    end
    if (n >= 600 || h >= 600) timeout();
  endtask
  //////////////////////////////
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && rdQ.size() > 0) begin
      note = rdQ.pop_front();
      check({pslverr, prdata} & note[65:33], note[32:0]);
    end
    if (nRx != seen) begin
      seen = nRx;
      check({25'h0000000, rxByte}, {25'h0000000, byteQ.pop_front()});
    end
  end
  //////////////////////////////
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ssIn_n = 1'b1;
    txByte = 8'h00;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`ADDR_RATE, 8'hFF, 8'h00);
    rd(`ADDR_DATA, 8'hFF, 8'h00);
    wr(`ADDR_FLAGS, 8'hFF);
    rd(`ADDR_FLAGS, 8'hFF, 8'h20);
    apb(1'b0, 8'h14, 8'h00, {33{1'b1}}, {1'b1, 32'h00000000});
    wr(`ADDR_CTRL1, 8'h50);
    foreach (preT[i]) begin
      r = rand8();
      wr(`ADDR_RATE, r);
      rd(`ADDR_RATE, 8'hFF, r & 8'h77);
      wr(`ADDR_RATE, {1'b0, 3'(preT[i]), 1'b0, 3'(divT[i])});
      sTx = rand8();
      txByte <= sTx;
      send(rand8());
      rd(`ADDR_FLAGS, 8'h20, 8'h20);
      halfPeriod(c);
      check(33'(c), 33'((preT[i] + 1) << divT[i]));
      waitRx(want, 1'b1);
      rd(`ADDR_FLAGS, 8'hB0, 8'hA0);
      rd(`ADDR_DATA, 8'hFF, sTx);
      rd(`ADDR_FLAGS, 8'h80, 8'h00);
    end
    // a second write with no fresh flag read is dropped
    send(8'h3C);
    wr(`ADDR_DATA, 8'hC3);
    waitRx(want, 1'b1);
    repeat (300) @(posedge sys_clk);
    check({32'h00000000, ssOut_n}, 33'h000000001);
    check(33'(nRx), 33'(want));
    rd(`ADDR_FLAGS, 8'h80, 8'h80);
    rd(`ADDR_DATA, 8'hFF, sTx);
    // queued byte follows; its received byte is lost to overrun
    sTx = rand8();
    txByte <= sTx;
    send(8'h5A);
    send(8'hA5);
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    waitRx(want - 1, 1'b0);
    txByte <= ~sTx;
    waitRx(want, 1'b1);
    rd(`ADDR_FLAGS, 8'hB0, 8'hA0);
    rd(`ADDR_DATA, 8'hFF, sTx);
    // receive full with general enable
    wr(`ADDR_CTRL1, 8'hD0);
    send(8'h96);
    waitRx(want, 1'b1);
    @(posedge sys_clk);
    check({32'h00000000, irq}, 33'h000000001);
    // disable mid-transfer
    rd(`ADDR_FLAGS, 8'h20, 8'h20);
    wr(`ADDR_DATA, 8'h81);
    repeat (20) @(posedge sys_clk);
    wr(`ADDR_CTRL1, 8'h30);
    rd(`ADDR_FLAGS, 8'hB0, 8'h20);
    rd(`ADDR_DATA, 8'hFF, 8'h00);
    check({32'h00000000, ssOut_n}, 33'h000000001);
    check({32'h00000000, irq}, 33'h000000001);
    wr(`ADDR_CTRL1, 8'h10);
    @(posedge sys_clk);
    check({32'h00000000, irq}, 33'h000000000);
    // mode fault only with fault input role
    wr(`ADDR_CTRL2, 8'h10);
    wr(`ADDR_CTRL1, 8'h50);
    ssIn_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(`ADDR_FLAGS, 8'h10, 8'h10);
    wr(`ADDR_CTRL1, 8'h50);
    rd(`ADDR_FLAGS, 8'h10, 8'h00);
    ssIn_n <= 1'b1;
    wr(`ADDR_CTRL1, 8'h52);
    @(posedge sys_clk);
    check({32'h00000000, ssOutEn}, 33'h000000001);
    ssIn_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(`ADDR_FLAGS, 8'h10, 8'h00);
    repeat (4) @(posedge sys_clk);
    report_and_stop();
  end
endmodule // tb_spi_rate_status_data_regs
`default_nettype wire
